// *** rtl/srpd_dev.sv ***
// What this block does
// - descriptor words at table offsets 30h-37h, LSB first
// - erase suspend opcode 75h, bits 31:24, pauses erase
// - erase resume opcode 7Ah, bits 23:16, continues erase
// - program suspend 85h, bits 15:8, pauses program
// - program resume 8Ah, bits 7:0, continues program
// - second word bit 31 set: no deep power-down
// - power-down enter/exit opcode fields read FFh
// - exit delay unit 11b, count 11111b
// - busy polling field 3:2 reads 01b
// - status read 05h, bit 0 busy
// - reserved bits 7:4 Fh, bits 1:0 11b
`timescale 1ns/100ps
`include "srpd_cfg.svh"
module srpd_dev
	import srpd_pkg::*;
(
	input wire logic i_clk_sys, // system clock, 20 MHz
	input wire logic i_srst, // synchronous reset, active high
	srpd_link_if.dev lnk, // serial link to the host
	input wire logic i_erase_start, // pulse: begin an erase
	input wire logic i_prog_start, // pulse: begin a page program
	input wire logic i_op_done, // pulse: running operation finished
	output logic o_busy, // status busy bit
	output srpd_op_e o_erase_state, // erase idle/run/suspended
	output srpd_op_e o_prog_state // program idle/run/suspended
);

	srpd_dev_s cur_r;
	srpd_dev_s cur_nxt;

	function automatic logic [31:0] word13();
		logic [31:0] w;
		w = '0;
		w[`SRPD_W13_ERS_SUSP_MSB:`SRPD_W13_ERS_SUSP_LSB] =
			`SRPD_OP_ERS_SUSP;
		w[`SRPD_W13_ERS_RES_MSB:`SRPD_W13_ERS_RES_LSB] =
			`SRPD_OP_ERS_RES;
		w[`SRPD_W13_PGM_SUSP_MSB:`SRPD_W13_PGM_SUSP_LSB] =
			`SRPD_OP_PGM_SUSP;
		w[`SRPD_W13_PGM_RES_MSB:`SRPD_W13_PGM_RES_LSB] =
			`SRPD_OP_PGM_RES;
		return w;
	endfunction : word13

	function automatic logic [31:0] word14();
		logic [31:0] w;
		w = '0;
		w[`SRPD_W14_DPD_ABSENT_BIT] = `SRPD_W14_DPD_ABSENT;
		w[`SRPD_W14_DPD_ENTER_MSB:`SRPD_W14_DPD_ENTER_LSB] =
			`SRPD_W14_DPD_UNSUP_OP;
		w[`SRPD_W14_DPD_EXIT_MSB:`SRPD_W14_DPD_EXIT_LSB] =
			`SRPD_W14_DPD_UNSUP_OP;
		w[`SRPD_W14_DLY_UNIT_MSB:`SRPD_W14_DLY_UNIT_LSB] =
			`SRPD_W14_DLY_UNIT;
		w[`SRPD_W14_DLY_CNT_MSB:`SRPD_W14_DLY_CNT_LSB] =
			`SRPD_W14_DLY_CNT;
		w[`SRPD_W14_RSVD_HI_MSB:`SRPD_W14_RSVD_HI_LSB] =
			`SRPD_W14_RSVD_HI;
		w[`SRPD_W14_POLL_MSB:`SRPD_W14_POLL_LSB] =
			`SRPD_W14_POLL_LEGACY;
		w[`SRPD_W14_RSVD_LO_MSB:`SRPD_W14_RSVD_LO_LSB] =
			`SRPD_W14_RSVD_LO;
		return w;
	endfunction : word14

	// one byte of the parameter table; words are sent low byte first
	function automatic logic [7:0] param_byte(input logic [23:0] a);
		logic [31:0] w;
		logic [7:0] b;
		w = '0;
		b = `SRPD_UNMAPPED_BYTE;
		if ({2'b00, a[23:2]} == (`SRPD_W13_OFFS >> 2))
		begin
			w = word13();
			b = w[8 * a[1:0] +: 8];
		end
		else if ({2'b00, a[23:2]} == (`SRPD_W14_OFFS >> 2))
		begin
			w = word14();
			b = w[8 * a[1:0] +: 8];
		end
		return b;
	endfunction : param_byte

	function automatic logic is_busy(input srpd_op_e e,
		input srpd_op_e p);
		return (e == SRPD_RUN) || (p == SRPD_RUN);
	endfunction : is_busy

	logic rise;
	logic fall;
	logic sel;
	logic byte_done;
	logic [7:0] byte_in;
	logic [7:0] status;
	logic [7:0] next_tx;
	logic [23:0] rd_addr;

	always_comb
	begin
		cur_nxt = cur_r;
		// sync stage 1 feeds only stage 2
		cur_nxt.sclk_s1 = lnk.sclk;
		cur_nxt.sclk_s2 = cur_r.sclk_s1;
		cur_nxt.sclk_d = cur_r.sclk_s2;
		cur_nxt.csn_s1 = lnk.cs_n;
		cur_nxt.csn_s2 = cur_r.csn_s1;
		cur_nxt.mosi_s1 = lnk.mosi;
		cur_nxt.mosi_s2 = cur_r.mosi_s1;

		sel = !cur_r.csn_s2;
		rise = sel && cur_r.sclk_s2 && !cur_r.sclk_d;
		fall = sel && !cur_r.sclk_s2 && cur_r.sclk_d;
		byte_in = {cur_r.shin[6:0], cur_r.mosi_s2};
		byte_done = rise && (cur_r.bitcnt == 3'h7);
		status = 8'h00;
		status[`SRPD_STAT_BUSY_BIT] = is_busy(cur_r.ers, cur_r.pgm);
		rd_addr = cur_r.addr + 24'(cur_r.bytecnt - `SRPD_PARAM_DATA_IDX);

		next_tx = 8'hFF;
		if (cur_r.op == `SRPD_OP_RD_STAT)
		begin
			next_tx = status;
		end
		else if (cur_r.op == `SRPD_OP_RD_PARAM &&
			cur_r.bytecnt >= `SRPD_PARAM_DATA_IDX)
		begin
			next_tx = param_byte(rd_addr);
		end

		if (!sel)
		begin
			cur_nxt.bitcnt = 3'h0;
			cur_nxt.bytecnt = 4'h0;
			cur_nxt.op = 8'h00;
			cur_nxt.miso_oe_n = 1'b1;
		end
		else
		begin
			cur_nxt.miso_oe_n = 1'b0;
			if (rise)
			begin
				cur_nxt.shin = byte_in;
				cur_nxt.bitcnt = cur_r.bitcnt + 3'h1;
			end
			if (fall)
			begin
				// a new byte starts after bit 7, so load then
				if (cur_r.bitcnt == 3'h0)
				begin
					cur_nxt.tx = next_tx;
				end
				else
				begin
					cur_nxt.tx = {cur_r.tx[6:0], 1'b1};
				end
			end
			if (byte_done)
			begin
				// saturate so long reads do not wrap the index
				if (cur_r.bytecnt != 4'hF)
				begin
					cur_nxt.bytecnt = cur_r.bytecnt + 4'h1;
				end
				if (cur_r.bytecnt == 4'h0)
				begin
					cur_nxt.op = byte_in;
				end
				else if (cur_r.bytecnt < 4'h4)
				begin
					cur_nxt.addr = {cur_r.addr[15:0], byte_in};
				end
			end
		end

		// suspend and resume act as soon as the opcode byte is in
		if (byte_done && cur_r.bytecnt == 4'h0)
		begin
			case (byte_in)
				`SRPD_OP_ERS_SUSP:
				begin
					if (cur_r.ers == SRPD_RUN && cur_r.pgm == SRPD_IDLE)
					begin
						cur_nxt.ers = SRPD_SUSP;
					end
				end
				`SRPD_OP_ERS_RES:
				begin
					if (cur_r.ers == SRPD_SUSP && cur_r.pgm == SRPD_IDLE)
					begin
						cur_nxt.ers = SRPD_RUN;
					end
				end
				`SRPD_OP_PGM_SUSP:
				begin
					if (cur_r.pgm == SRPD_RUN)
					begin
						cur_nxt.pgm = SRPD_SUSP;
					end
				end
				`SRPD_OP_PGM_RES:
				begin
					if (cur_r.pgm == SRPD_SUSP)
					begin
						cur_nxt.pgm = SRPD_RUN;
					end
				end
				default:
				begin
					cur_nxt.op = byte_in;
				end
			endcase
		end

		// array operations stand in for the out-of-scope flash core
		if (i_op_done)
		begin
			if (cur_r.pgm == SRPD_RUN)
			begin
				cur_nxt.pgm = SRPD_IDLE;
			end
			else if (cur_r.ers == SRPD_RUN)
			begin
				cur_nxt.ers = SRPD_IDLE;
			end
		end
		else if (i_prog_start && cur_r.pgm == SRPD_IDLE &&
			cur_r.ers != SRPD_RUN)
		begin
			cur_nxt.pgm = SRPD_RUN;
		end
		else if (i_erase_start && cur_r.ers == SRPD_IDLE &&
			cur_r.pgm == SRPD_IDLE)
		begin
			cur_nxt.ers = SRPD_RUN;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			cur_r <= '{sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_d: 1'b0,
				csn_s1: 1'b1, csn_s2: 1'b1, mosi_s1: 1'b0,
				mosi_s2: 1'b0, bitcnt: 3'h0, bytecnt: 4'h0,
				shin: 8'h00, op: 8'h00, addr: 24'h000000,
				tx: 8'hFF, miso_oe_n: 1'b1, ers: SRPD_IDLE,
				pgm: SRPD_IDLE};
		end
		else
		begin
			cur_r <= cur_nxt;
		end
	end

	assign lnk.miso = cur_r.tx[7];
	assign lnk.miso_oe_n = cur_r.miso_oe_n;
	assign o_busy = is_busy(cur_r.ers, cur_r.pgm);
	assign o_erase_state = cur_r.ers;
	assign o_prog_state = cur_r.pgm;

endmodule : srpd_dev

// *** rtl/srpd_cfg.svh ***
`ifndef SRPD_CFG_SVH
`define SRPD_CFG_SVH

// opcodes
`define SRPD_OP_ERS_SUSP 8'h75
`define SRPD_OP_ERS_RES 8'h7A
`define SRPD_OP_PGM_SUSP 8'h85
`define SRPD_OP_PGM_RES 8'h8A
`define SRPD_OP_RD_STAT 8'h05
`define SRPD_OP_RD_PARAM 8'h5A

// descriptor word 13 field positions
`define SRPD_W13_ERS_SUSP_MSB 31
`define SRPD_W13_ERS_SUSP_LSB 24
`define SRPD_W13_ERS_RES_MSB 23
`define SRPD_W13_ERS_RES_LSB 16
`define SRPD_W13_PGM_SUSP_MSB 15
`define SRPD_W13_PGM_SUSP_LSB 8
`define SRPD_W13_PGM_RES_MSB 7
`define SRPD_W13_PGM_RES_LSB 0

// descriptor word 14 field positions and values
`define SRPD_W14_DPD_ABSENT_BIT 31
`define SRPD_W14_DPD_ABSENT 1'h1
`define SRPD_W14_DPD_ENTER_MSB 30
`define SRPD_W14_DPD_ENTER_LSB 23
`define SRPD_W14_DPD_EXIT_MSB 22
`define SRPD_W14_DPD_EXIT_LSB 15
`define SRPD_W14_DPD_UNSUP_OP 8'hFF
`define SRPD_W14_DLY_UNIT_MSB 14
`define SRPD_W14_DLY_UNIT_LSB 13
`define SRPD_W14_DLY_UNIT 2'h3
`define SRPD_W14_DLY_CNT_MSB 12
`define SRPD_W14_DLY_CNT_LSB 8
`define SRPD_W14_DLY_CNT 5'h1F
`define SRPD_W14_RSVD_HI_MSB 7
`define SRPD_W14_RSVD_HI_LSB 4
`define SRPD_W14_RSVD_HI 4'hF
`define SRPD_W14_POLL_MSB 3
`define SRPD_W14_POLL_LSB 2
`define SRPD_W14_POLL_LEGACY 2'h1
`define SRPD_W14_RSVD_LO_MSB 1
`define SRPD_W14_RSVD_LO_LSB 0
`define SRPD_W14_RSVD_LO 2'h3

// parameter table placement (discoverable table offsets)
`define SRPD_W13_OFFS 24'h000030
`define SRPD_W14_OFFS 24'h000034
`define SRPD_LEGACY_W13_OFFS 24'h000032
`define SRPD_UNMAPPED_BYTE 8'hFF

// status register
`define SRPD_STAT_BUSY_BIT 0

// transaction shape
`define SRPD_PARAM_DATA_IDX 4'h5
`define SRPD_PARAM_BYTES 4'h9
`define SRPD_STAT_BYTES 4'h2
`define SRPD_CMD_BYTES 4'h1

// host serial clock half period in system clocks
`define SRPD_HALF_PERIOD 4'h8

`endif

// *** rtl/srpd_pkg.sv ***
package srpd_pkg;

	typedef enum logic [1:0] {SRPD_IDLE, SRPD_RUN, SRPD_SUSP} srpd_op_e;

	typedef enum logic [1:0] {SRPD_H_IDLE, SRPD_H_LOW, SRPD_H_HIGH,
		SRPD_H_END} srpd_hst_e;

	typedef struct packed {
		logic sclk_s1;
		logic sclk_s2;
		logic sclk_d;
		logic csn_s1;
		logic csn_s2;
		logic mosi_s1;
		logic mosi_s2;
		logic [2:0] bitcnt;
		logic [3:0] bytecnt;
		logic [7:0] shin;
		logic [7:0] op;
		logic [23:0] addr;
		logic [7:0] tx;
		logic miso_oe_n;
		srpd_op_e ers;
		srpd_op_e pgm;
	} srpd_dev_s;

	typedef struct packed {
		srpd_hst_e st;
		logic [3:0] div;
		logic sclk;
		logic csn;
		logic [7:0] txsr;
		logic [2:0] bitcnt;
		logic [3:0] bytecnt;
		logic [3:0] nbytes;
		logic [7:0] op;
		logic [7:0] addr;
		logic [7:0] rxsr;
		logic [31:0] rxword;
		logic miso_s1;
		logic miso_s2;
		logic rsp_valid;
		logic [31:0] rsp_data;
	} srpd_hst_s;

endpackage : srpd_pkg

// *** rtl/srpd_link_if.sv ***
`timescale 1ns/100ps
interface srpd_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe_n;

	modport dev (
		input sclk,
		input cs_n,
		input mosi,
		output miso,
		output miso_oe_n
	);

	modport hst (
		output sclk,
		output cs_n,
		output mosi,
		input miso,
		input miso_oe_n
	);
endinterface : srpd_link_if

// *** rtl/srpd_hst.sv ***
`timescale 1ns/100ps
`include "srpd_cfg.svh"
module srpd_hst
	import srpd_pkg::*;
(
	input wire logic i_clk_sys, // system clock, 20 MHz
	input wire logic i_srst, // synchronous reset, active high
	srpd_link_if.hst lnk, // serial link to the device
	input wire logic i_cmd_valid, // request: opcode and address valid
	input wire logic [7:0] i_cmd_op, // opcode to issue
	input wire logic [7:0] i_cmd_addr, // table offset for parameter read
	output logic o_cmd_ready, // host idle, request taken
	output logic o_rsp_valid, // pulse: transaction finished
	output logic [31:0] o_rsp_data // status byte or descriptor word
);

	srpd_hst_s cur_r;
	srpd_hst_s cur_nxt;

	function automatic logic [3:0] byte_len(input logic [7:0] op);
		logic [3:0] n;
		n = `SRPD_CMD_BYTES;
		if (op == `SRPD_OP_RD_STAT)
		begin
			n = `SRPD_STAT_BYTES;
		end
		else if (op == `SRPD_OP_RD_PARAM)
		begin
			n = `SRPD_PARAM_BYTES;
		end
		return n;
	endfunction : byte_len

	function automatic logic [7:0] tx_byte(input logic [3:0] idx,
		input logic [7:0] op, input logic [7:0] addr);
		logic [7:0] b;
		b = 8'h00;
		if (idx == 4'h0)
		begin
			b = op;
		end
		else if (idx == 4'h3)
		begin
			b = addr;
		end
		return b;
	endfunction : tx_byte

	logic [7:0] rx_byte;
	logic last_bit;

	always_comb
	begin
		cur_nxt = cur_r;
		// a released line reads as its pull-up level
		cur_nxt.miso_s1 = lnk.miso | lnk.miso_oe_n;
		cur_nxt.miso_s2 = cur_r.miso_s1;
		cur_nxt.rsp_valid = 1'b0;
		rx_byte = {cur_r.rxsr[6:0], cur_r.miso_s2};
		last_bit = cur_r.bitcnt == 3'h7;
		if (cur_r.div != 4'h0)
		begin
			cur_nxt.div = cur_r.div - 4'h1;
		end
		case (cur_r.st)
			SRPD_H_IDLE:
			begin
				if (i_cmd_valid)
				begin
					cur_nxt.st = SRPD_H_LOW;
					cur_nxt.csn = 1'b0;
					cur_nxt.op = i_cmd_op;
					cur_nxt.addr = i_cmd_addr;
					cur_nxt.nbytes = byte_len(i_cmd_op);
					cur_nxt.txsr = tx_byte(4'h0, i_cmd_op, i_cmd_addr);
					cur_nxt.bitcnt = 3'h0;
					cur_nxt.bytecnt = 4'h0;
					cur_nxt.div = `SRPD_HALF_PERIOD - 4'h1;
				end
			end
			SRPD_H_LOW:
			begin
				if (cur_r.div == 4'h0)
				begin
					// miso moved 3 cycles into this 8-cycle low phase and has had 5 cycles to settle and sync
					cur_nxt.st = SRPD_H_HIGH;
					cur_nxt.sclk = 1'b1;
					cur_nxt.rxsr = rx_byte;
					cur_nxt.div = `SRPD_HALF_PERIOD - 4'h1;
					if (last_bit && cur_r.bytecnt >= `SRPD_PARAM_DATA_IDX)
					begin
						cur_nxt.rxword = {rx_byte, cur_r.rxword[31:8]};
					end
					else if (last_bit && cur_r.bytecnt == 4'h1)
					begin
						cur_nxt.rxword = {24'h000000, rx_byte};
					end
				end
			end
			SRPD_H_HIGH:
			begin
				if (cur_r.div == 4'h0)
				begin
					cur_nxt.sclk = 1'b0;
					cur_nxt.div = `SRPD_HALF_PERIOD - 4'h1;
					cur_nxt.bitcnt = cur_r.bitcnt + 3'h1;
					if (!last_bit)
					begin
						cur_nxt.st = SRPD_H_LOW;
						cur_nxt.txsr = {cur_r.txsr[6:0], 1'b0};
					end
					else if (cur_r.bytecnt + 4'h1 == cur_r.nbytes)
					begin
						cur_nxt.st = SRPD_H_END;
					end
					else
					begin
						cur_nxt.st = SRPD_H_LOW;
						cur_nxt.bytecnt = cur_r.bytecnt + 4'h1;
						cur_nxt.txsr = tx_byte(cur_r.bytecnt + 4'h1,
							cur_r.op, cur_r.addr);
					end
				end
			end
			SRPD_H_END:
			begin
				if (cur_r.div == 4'h0)
				begin
					cur_nxt.st = SRPD_H_IDLE;
					cur_nxt.csn = 1'b1;
					cur_nxt.rsp_valid = 1'b1;
					cur_nxt.rsp_data = cur_r.rxword;
				end
			end
			default:
			begin
				cur_nxt.st = SRPD_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			cur_r <= '{st: SRPD_H_IDLE, div: 4'h0, sclk: 1'b0,
				csn: 1'b1, txsr: 8'h00, bitcnt: 3'h0, bytecnt: 4'h0,
				nbytes: 4'h0, op: 8'h00, addr: 8'h00, rxsr: 8'h00,
				rxword: 32'h00000000, miso_s1: 1'b0, miso_s2: 1'b0,
				rsp_valid: 1'b0, rsp_data: 32'h00000000};
		end
		else
		begin
			cur_r <= cur_nxt;
		end
	end

	assign lnk.sclk = cur_r.sclk;
	assign lnk.cs_n = cur_r.csn;
	assign lnk.mosi = cur_r.txsr[7];
	assign o_cmd_ready = cur_r.st == SRPD_H_IDLE;
	assign o_rsp_valid = cur_r.rsp_valid;
	assign o_rsp_data = cur_r.rsp_data;

endmodule : srpd_hst

// *** bench/srpd_link_asserts.sv ***
`timescale 1ns/100ps
module srpd_link_asserts (
	input wire logic i_clk_sys, // system clock
	input wire logic i_srst, // synchronous reset
	input wire logic i_sclk, // link clock from host
	input wire logic i_cs_n, // select, active low
	input wire logic i_mosi, // host to device data
	input wire logic i_miso, // device to host data
	input wire logic i_miso_oe_n // device drive enable, active low
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	sequence s_high;
		i_sclk [*8];
	endsequence

	sequence s_low;
		!i_sclk [*8];
	endsequence

	reset_idle_a: assert property (
		$fell(i_srst) |-> i_cs_n && !i_sclk && i_miso_oe_n)
		else $error("link not idle after reset");
	sclk_idle_a: assert property (
		i_cs_n && $past(i_cs_n) |-> !i_sclk)
		else $error("link clock moved while deselected");
	first_edge_a: assert property (
		$fell(i_cs_n) |-> !i_sclk [*7] ##[1:3] i_sclk)
		else $error("first clock rise misplaced after select");
	high_phase_a: assert property (
		$rose(i_sclk) |-> s_high ##1 !i_sclk)
		else $error("link clock high phase not 8 cycles");
	low_phase_a: assert property (
		$fell(i_sclk) |-> s_low ##[1:2] (i_sclk || i_cs_n))
		else $error("link clock low phase wrong");
	mosi_hold_a: assert property (
		i_sclk && $past(i_sclk) |-> $stable(i_mosi))
		else $error("host data moved while clock high");
	oe_drive_a: assert property (
		!i_cs_n [*5] |-> !i_miso_oe_n)
		else $error("device not driving while selected");
	oe_release_a: assert property (
		i_cs_n [*5] |-> i_miso_oe_n)
		else $error("device still driving while deselected");
	miso_hold_a: assert property (
		!i_miso_oe_n && i_sclk && $past(i_sclk) |-> $stable(i_miso))
		else $error("device data moved while clock high");
endmodule : srpd_link_asserts

// *** bench/suspend_resume_param_descriptor_tb.sv ***
`timescale 1ns/100ps
module suspend_resume_param_descriptor_tb import srpd_pkg::*;;
	logic i_clk_sys = 1'b0;
	logic i_srst = 1'b1;
	logic erase_start = 1'b0;
	logic prog_start = 1'b0;
	logic op_done = 1'b0;
	logic cmd_valid = 1'b0;
	logic [7:0] cmd_op = 8'h00;
	logic [7:0] cmd_addr = 8'h00;
	logic busy, cmd_ready, rsp_valid;
	logic [31:0] rsp_data;
	srpd_op_e erase_state, prog_state, ers_m, pgm_m;
	int num_errors = 0;
	int samples_checked = 0;
	integer seed = 32'h8534C41A;
	logic sclk_d = 1'b0;
	logic [7:0] ms, ss;
	int nbits = 0;
	logic [7:0] mq[$];
	logic [7:0] sq[$];
	int prefix[14] = '{3, 6, 0, 5, 3, 1, 5, 4, 6, 7, 2, 4, 8, 8};
	logic [7:0] ops[10] = '{8'h00, 8'h00, 8'h00, 8'h75, 8'h7A, 8'h85,
		8'h8A, 8'h05, 8'h5A, 8'h3C};

	srpd_link_if lnk ();
	srpd_dev i_srpd_dev (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .lnk(lnk),
		.i_erase_start(erase_start), .i_prog_start(prog_start),
		.i_op_done(op_done), .o_busy(busy), .o_erase_state(erase_state),
		.o_prog_state(prog_state));
	srpd_hst i_srpd_hst (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .lnk(lnk),
		.i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_addr(cmd_addr),
		.o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid),
		.o_rsp_data(rsp_data));
	srpd_link_asserts i_srpd_link_asserts (.i_clk_sys(i_clk_sys),
		.i_srst(i_srst), .i_sclk(lnk.sclk), .i_cs_n(lnk.cs_n),
		.i_mosi(lnk.mosi), .i_miso(lnk.miso),
		.i_miso_oe_n(lnk.miso_oe_n));

	initial
	begin
		forever #25 i_clk_sys = ~i_clk_sys;
	end

	// bytes on the wire, shifted at each link clock rise inside a frame
	always @(posedge i_clk_sys)
	begin
		if (lnk.cs_n)
			nbits = 0;
		else if (lnk.sclk && !sclk_d)
		begin
			ms = {ms[6:0], lnk.mosi};
			ss = {ss[6:0], lnk.miso};
			nbits++;
			if (nbits % 8 == 0)
			begin
				mq.push_back(ms);
				sq.push_back(ss);
			end
		end
		sclk_d = lnk.sclk;
	end

	task automatic check(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic conclude();
		if (num_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	function automatic logic [7:0] pbyte(input logic [7:0] a);
		logic [63:0] t;
		t = {1'b1, 8'hFF, 8'hFF, 2'h3, 5'h1F, 4'hF, 2'h1, 2'h3,
			8'h75, 8'h7A, 8'h85, 8'h8A};
		return (a >= 8'h30 && a <= 8'h37) ? t[(a - 8'h30) * 8 +: 8] : 8'hFF;
	endfunction : pbyte

	task automatic pulse(input int k);
		@(negedge i_clk_sys);
		{erase_start, prog_start, op_done} = 3'b100 >> k;
		@(negedge i_clk_sys);
		{erase_start, prog_start, op_done} = 3'b000;
	endtask : pulse

	// the request is held until the host is idle, so it is never dropped
	task automatic cmd(input logic [7:0] op, input logic [7:0] adr);
		int n;
		mq.delete();
		sq.delete();
		@(negedge i_clk_sys);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = adr;
		while (cmd_ready !== 1'b1)
			@(negedge i_clk_sys);
		@(negedge i_clk_sys);
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 3000)
		begin
			@(negedge i_clk_sys);
			n++;
		end
		check("response", 32'(rsp_valid), 32'h1);
		check("ready after response", 32'(cmd_ready), 32'h1);
		check("opcode on wire", 32'(mq[0]), 32'(op));
	endtask : cmd

	initial
	begin
		int act;
		logic [7:0] a;
		logic [31:0] w;
		repeat (2) @(negedge i_clk_sys);
		i_srst = 1'b0;
		ers_m = SRPD_IDLE;
		pgm_m = SRPD_IDLE;
		for (int k = 0; k < 70; k++)
		begin
			act = k < 14 ? prefix[k] : $unsigned($random(seed)) % 10;
			a = 8'h28 + 8'($unsigned($random(seed)) % 24);
			if (k >= 12 && k < 14)
				a = k == 12 ? 8'h30 : 8'h34;
			if (act < 3)
				pulse(act);
			else
				cmd(ops[act], a);
			case (act)
				0: if (ers_m == SRPD_IDLE && pgm_m == SRPD_IDLE) ers_m = SRPD_RUN;
				1: if (pgm_m == SRPD_IDLE && ers_m != SRPD_RUN) pgm_m = SRPD_RUN;
				2: if (pgm_m == SRPD_RUN) pgm_m = SRPD_IDLE;
					else if (ers_m == SRPD_RUN) ers_m = SRPD_IDLE;
				3: if (ers_m == SRPD_RUN && pgm_m == SRPD_IDLE) ers_m = SRPD_SUSP;
				4: if (ers_m == SRPD_SUSP && pgm_m == SRPD_IDLE) ers_m = SRPD_RUN;
				5: if (pgm_m == SRPD_RUN) pgm_m = SRPD_SUSP;
				6: if (pgm_m == SRPD_SUSP) pgm_m = SRPD_RUN;
				default: ;
			endcase
			repeat (4) @(negedge i_clk_sys);
			w = {pbyte(a + 8'h3), pbyte(a + 8'h2), pbyte(a + 8'h1), pbyte(a)};
			check("erase state", 32'(erase_state), 32'(ers_m));
			check("program state", 32'(prog_state), 32'(pgm_m));
			check("busy", 32'(busy), 32'(ers_m == SRPD_RUN || pgm_m == SRPD_RUN));
			if (act == 7)
				check("status bit", 32'(rsp_data[0]),
					32'(ers_m == SRPD_RUN || pgm_m == SRPD_RUN));
			if (act == 8)
				check("descriptor word", rsp_data, w);
			if (act == 8)
				check("wire bytes", {sq[8], sq[7], sq[6], sq[5]}, w);
		end
		conclude();
	end

	initial
	begin
		repeat (100000) @(posedge i_clk_sys);
		num_errors++;
		conclude();
	end
endmodule : suspend_resume_param_descriptor_tb
